// >>> core/pds_access.v
// Purpose: Program and data space access for a 16-bit signal core
// Assumes: Memories answer one cycle after a registered strobe
// Notes:   One request in flight; busy_o high until done_o
`timescale 1ns/1ps
`include "pds_consts.vh"
module pds_access (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	input  wire        req_i,
	input  wire [2:0]  op_i,
	input  wire [1:0]  cls_i,
	input  wire        byte_i,
	input  wire [15:0] x_ea_i,
	input  wire [15:0] y_ea_i,
	input  wire [15:0] wdata_i,
	input  wire        x_mod_i,
	input  wire        y_mod_i,
	input  wire        bitrev_i,
	input  wire        rpt_in_i,
	input  wire        rpt_first_i,
	input  wire        rpt_last_i,
	input  wire        rpt_int_exit_i,
	input  wire        rpt_int_reentry_i,
	output wire        busy_o,
	output wire        done_o,
	output wire [15:0] rdata_o,
	output wire [15:0] y_rdata_o,
	output wire [15:0] x_next_ea_o,
	output wire [15:0] y_next_ea_o,
	output wire [23:0] prog_addr_o,
	output wire        prog_cfg_o,
	output wire        prog_rd_o,
	output wire [2:0]  prog_wen_o,
	output wire [23:0] prog_wdata_o,
	input  wire [23:0] prog_rdata_i,
	output wire [15:0] x_addr_o,
	output wire        x_rd_o,
	output wire [1:0]  x_be_o,
	output wire [15:0] x_wdata_o,
	input  wire [15:0] x_rdata_i,
	output wire [15:0] y_addr_o,
	output wire        y_rd_o,
	input  wire [15:0] y_rdata_i
);
	localparam S_IDLE  = 4'b0001;
	localparam S_ISSUE = 4'b0010;
	localparam S_CAPT  = 4'b0100;
	localparam S_EXTRA = 4'b1000;

	// Software visible state
	reg        win_en_ff;
	reg [7:0]  wpage_ff;
	reg [7:0]  tpage_ff;
	reg [15:0] xms_ff;
	reg [15:0] xme_ff;
	reg [15:0] yms_ff;
	reg [15:0] yme_ff;
	reg [15:0] brev_ff;
	reg        ack_ff;
	reg [31:0] dat_ff;
	reg [31:0] nxt_dat;

	// Access sequencing
	reg [3:0]  state_ff;
	reg [1:0]  cnt_ff;
	reg [2:0]  op_ff;
	reg        byte_ff;
	reg        bsel_ff;
	reg        xzero_ff;
	reg        yzero_ff;
	reg        win_ff;
	reg [1:0]  extra_ff;
	reg        busy_ff;
	reg        done_ff;
	reg [15:0] rdata_ff;
	reg [15:0] yrdata_ff;
	reg [15:0] xnext_ff;
	reg [15:0] ynext_ff;
	reg        last_zero_ff;
	reg        last_win_ff;

	// Memory strobes
	reg [23:0] paddr_ff;
	reg        pcfg_ff;
	reg        prd_ff;
	reg [2:0]  pwen_ff;
	reg [23:0] pwdata_ff;
	reg [15:0] xaddr_ff;
	reg        xrd_ff;
	reg [1:0]  xbe_ff;
	reg [15:0] xwdata_ff;
	reg [15:0] yaddr_ff;
	reg        yrd_ff;

	wire        is_tbl;
	wire        is_trd;
	wire        is_mac;
	wire        is_rd;
	wire        x_win;
	wire        x_in_y;
	wire        y_in_y;
	wire        x_impl;
	wire        x_zero;
	wire        y_zero;
	wire        bsel;
	wire [1:0]  cost;
	wire [15:0] xnext;
	wire [15:0] ynext;
	wire        wb_req;
	wire        wb_wr;
	reg  [23:0] nxt_paddr;
	reg  [2:0]  nxt_pwen;
	reg  [23:0] nxt_pwdata;
	reg  [15:0] src;
	reg  [15:0] nxt_rdata;

	function [15:0] wr16;
		input [15:0] old;
		input [15:0] dat;
		input [1:0]  sel;
		begin
			wr16 = {sel[1] ? dat[15:8] : old[15:8],
				sel[0] ? dat[7:0] : old[7:0]};
		end
	endfunction

	// Request decode, taken straight from the core inputs
	assign is_tbl = (op_i == `PDS_OP_TRL) || (op_i == `PDS_OP_TRH) ||
		(op_i == `PDS_OP_TWL) || (op_i == `PDS_OP_TWH);
	assign is_trd = (op_i == `PDS_OP_TRL) || (op_i == `PDS_OP_TRH);
	assign is_mac = (op_i == `PDS_OP_MAC);
	assign is_rd  = (op_i == `PDS_OP_RD) || is_mac;
	assign bsel   = x_ea_i[0];
	assign x_win  = !is_tbl && x_ea_i[`PDS_WIN_BIT] && win_en_ff;
	assign x_in_y = (x_ea_i >= `PDS_Y_BASE) && (x_ea_i <= `PDS_Y_TOP);
	assign y_in_y = (y_ea_i >= `PDS_Y_BASE) && (y_ea_i <= `PDS_Y_TOP);
	assign x_impl = (x_ea_i <= `PDS_RAM_TOP);
	// Y addresses stay legal for non-MAC reads
	assign x_zero = !x_win && (!x_impl || (is_mac && x_in_y));
	assign y_zero = !y_in_y;

	pds_cost u_cost (
		.win_i      (x_win),
		.cls_i      (cls_i),
		.rpt_in_i   (rpt_in_i),
		.rpt_edge_i (rpt_first_i | rpt_last_i |
			rpt_int_exit_i | rpt_int_reentry_i),
		.extra_o    (cost)
	);

	pds_agu u_agu_x (
		.ea_i        (x_ea_i),
		.step_i      (byte_i ? `PDS_STEP_BYTE : `PDS_STEP_WORD),
		.mod_en_i    (x_mod_i),
		.mod_start_i (xms_ff),
		.mod_end_i   (xme_ff),
		.rev_en_i    (bitrev_i && (op_i == `PDS_OP_WR)),
		.rev_mod_i   (brev_ff),
		.next_o      (xnext)
	);

	pds_agu u_agu_y (
		.ea_i        (y_ea_i),
		.step_i      (`PDS_STEP_WORD),
		.mod_en_i    (y_mod_i),
		.mod_start_i (yms_ff),
		.mod_end_i   (yme_ff),
		.rev_en_i    (1'b0),
		.rev_mod_i   (brev_ff),
		.next_o      (ynext)
	);

	// Program address and write lanes
	always @* begin
		nxt_paddr  = {1'b0, wpage_ff, x_ea_i[14:1], 1'b0};
		nxt_pwen   = 3'h0;
		nxt_pwdata = {8'h00, wdata_i};
		if (is_tbl) begin
			nxt_paddr = {tpage_ff, x_ea_i[15:1], 1'b0};
		end
		if (op_i == `PDS_OP_TWL) begin
			if (byte_i) begin
				nxt_pwen   = {1'b0, bsel, !bsel};
				nxt_pwdata = {8'h00, wdata_i[7:0], wdata_i[7:0]};
			end else begin
				nxt_pwen = 3'h3;
			end
		end else if (op_i == `PDS_OP_TWH) begin
			// Upper byte reached only here
			nxt_pwen   = (byte_i && bsel) ? 3'h0 : 3'h4;
			nxt_pwdata = {wdata_i[7:0], 16'h0000};
		end
	end

	// Read data selection at capture
	always @* begin
		src = x_rdata_i;
		if (xzero_ff) begin
			src = 16'h0000;
		end else if (op_ff == `PDS_OP_TRL || win_ff) begin
			src = prog_rdata_i[15:0];
		end else if (op_ff == `PDS_OP_TRH) begin
			src = {8'h00, prog_rdata_i[23:16]};
		end
		nxt_rdata = src;
		if (byte_ff) begin
			// High byte of a high table read is zero by construction
			nxt_rdata = {8'h00, bsel_ff ? src[15:8] : src[7:0]};
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_ff     <= S_IDLE;
			cnt_ff       <= `PDS_COST_NONE;
			op_ff        <= `PDS_OP_RD;
			byte_ff      <= 1'b0;
			bsel_ff      <= 1'b0;
			xzero_ff     <= 1'b0;
			yzero_ff     <= 1'b0;
			win_ff       <= 1'b0;
			extra_ff     <= `PDS_COST_NONE;
			busy_ff      <= 1'b0;
			done_ff      <= 1'b0;
			rdata_ff     <= 16'h0000;
			yrdata_ff    <= 16'h0000;
			xnext_ff     <= 16'h0000;
			ynext_ff     <= 16'h0000;
			last_zero_ff <= 1'b0;
			last_win_ff  <= 1'b0;
			paddr_ff     <= 24'h000000;
			pcfg_ff      <= 1'b0;
			prd_ff       <= 1'b0;
			pwen_ff      <= 3'h0;
			pwdata_ff    <= 24'h000000;
			xaddr_ff     <= 16'h0000;
			xrd_ff       <= 1'b0;
			xbe_ff       <= 2'h0;
			xwdata_ff    <= 16'h0000;
			yaddr_ff     <= 16'h0000;
			yrd_ff       <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			prd_ff  <= 1'b0;
			pwen_ff <= 3'h0;
			xrd_ff  <= 1'b0;
			xbe_ff  <= 2'h0;
			yrd_ff  <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				if (req_i) begin
					state_ff  <= S_ISSUE;
					busy_ff   <= 1'b1;
					op_ff     <= op_i;
					byte_ff   <= byte_i;
					bsel_ff   <= bsel;
					win_ff    <= x_win && is_rd;
					xzero_ff  <= x_zero && !is_tbl;
					yzero_ff  <= y_zero;
					extra_ff  <= is_rd ? cost : `PDS_COST_NONE;
					xnext_ff  <= xnext;
					ynext_ff  <= is_mac ? ynext : y_ea_i;
					paddr_ff  <= nxt_paddr;
					pcfg_ff   <= is_tbl && tpage_ff[7];
					prd_ff    <= is_trd || (x_win && is_rd);
					pwen_ff   <= nxt_pwen;
					pwdata_ff <= nxt_pwdata;
					xaddr_ff  <= x_ea_i;
					xrd_ff    <= is_rd && !x_win && !x_zero;
					yaddr_ff  <= y_ea_i;
					yrd_ff    <= is_mac && !y_zero;
					xwdata_ff <= byte_i ?
						{wdata_i[7:0], wdata_i[7:0]} : wdata_i;
					// Window writes are dropped, not mapped
					if (op_i == `PDS_OP_WR && x_impl) begin
						xbe_ff <= byte_i ?
							{bsel, !bsel} : 2'h3;
					end
				end
			end
			S_ISSUE: begin
				state_ff <= S_CAPT;
			end
			S_CAPT: begin
				rdata_ff     <= nxt_rdata;
				yrdata_ff    <= yzero_ff ? 16'h0000 : y_rdata_i;
				last_zero_ff <= xzero_ff ||
					(op_ff == `PDS_OP_MAC && yzero_ff);
				last_win_ff  <= win_ff;
				if (extra_ff != `PDS_COST_NONE) begin
					state_ff <= S_EXTRA;
					cnt_ff   <= extra_ff;
				end else begin
					state_ff <= S_IDLE;
					busy_ff  <= 1'b0;
					done_ff  <= 1'b1;
				end
			end
			S_EXTRA: begin
				cnt_ff <= cnt_ff - `PDS_COST_ONE;
				if (cnt_ff == `PDS_COST_ONE) begin
					state_ff <= S_IDLE;
					busy_ff  <= 1'b0;
					done_ff  <= 1'b1;
				end
			end
			default: begin
				state_ff <= S_IDLE;
				busy_ff  <= 1'b0;
			end
			endcase
		end
	end

	// Classic slave, one wait state; writes land on the ack edge
	// so a request dropped before ack commits nothing
	assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;

	always @* begin
		nxt_dat = 32'h00000000;
		case (wb_adr_i)
		`PDS_REG_CTRL:  nxt_dat[0] = win_en_ff;
		`PDS_REG_WPAGE: nxt_dat[7:0] = wpage_ff;
		`PDS_REG_TPAGE: nxt_dat[7:0] = tpage_ff;
		`PDS_REG_STAT:  nxt_dat[2:0] = {last_win_ff, last_zero_ff, busy_ff};
		`PDS_REG_XMS:   nxt_dat[15:0] = xms_ff;
		`PDS_REG_XME:   nxt_dat[15:0] = xme_ff;
		`PDS_REG_YMS:   nxt_dat[15:0] = yms_ff;
		`PDS_REG_YME:   nxt_dat[15:0] = yme_ff;
		`PDS_REG_BREV:  nxt_dat[15:0] = brev_ff;
		default:        nxt_dat = 32'h00000000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff    <= 1'b0;
			dat_ff    <= 32'h00000000;
			win_en_ff <= 1'b0;
			wpage_ff  <= 8'h00;
			tpage_ff  <= 8'h00;
			xms_ff    <= 16'h0000;
			xme_ff    <= 16'h0000;
			yms_ff    <= 16'h0000;
			yme_ff    <= 16'h0000;
			brev_ff   <= 16'h0000;
		end else begin
			ack_ff <= wb_req;
			if (wb_req) begin
				dat_ff <= wb_we_i ? 32'h00000000 : nxt_dat;
			end
			if (wb_wr && wb_sel_i[0]) begin
				case (wb_adr_i)
				`PDS_REG_CTRL:  win_en_ff <= wb_dat_i[0];
				`PDS_REG_WPAGE: wpage_ff <= wb_dat_i[7:0];
				`PDS_REG_TPAGE: tpage_ff <= wb_dat_i[7:0];
				default: ;
				endcase
			end
			if (wb_wr) begin
				case (wb_adr_i)
				`PDS_REG_XMS:
					xms_ff <= wr16(xms_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
				`PDS_REG_XME:
					xme_ff <= wr16(xme_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
				`PDS_REG_YMS:
					yms_ff <= wr16(yms_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
				`PDS_REG_YME:
					yme_ff <= wr16(yme_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
				`PDS_REG_BREV:
					brev_ff <= wr16(brev_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
				default: ;
				endcase
			end
		end
	end

	assign wb_dat_o     = dat_ff;
	assign wb_ack_o     = ack_ff;
	assign busy_o       = busy_ff;
	assign done_o       = done_ff;
	assign rdata_o      = rdata_ff;
	assign y_rdata_o    = yrdata_ff;
	assign x_next_ea_o  = xnext_ff;
	assign y_next_ea_o  = ynext_ff;
	assign prog_addr_o  = paddr_ff;
	assign prog_cfg_o   = pcfg_ff;
	assign prog_rd_o    = prd_ff;
	assign prog_wen_o   = pwen_ff;
	assign prog_wdata_o = pwdata_ff;
	assign x_addr_o     = xaddr_ff;
	assign x_rd_o       = xrd_ff;
	assign x_be_o       = xbe_ff;
	assign x_wdata_o    = xwdata_ff;
	assign y_addr_o     = yaddr_ff;
	assign y_rd_o       = yrd_ff;
endmodule

// >>> core/pds_agu.v
// Purpose: Post-modify address generation for one pointer
// Assumes: Modulo end is the last address stepped onto
// Notes:   Bit reversal takes precedence over modulo
`timescale 1ns/1ps
`include "pds_consts.vh"
module pds_agu (
	input  wire [15:0] ea_i,
	input  wire [15:0] step_i,
	input  wire        mod_en_i,
	input  wire [15:0] mod_start_i,
	input  wire [15:0] mod_end_i,
	input  wire        rev_en_i,
	input  wire [15:0] rev_mod_i,
	output reg  [15:0] next_o
);
	wire [15:0] rev_ea;
	wire [15:0] rev_mod;
	wire [15:0] rev_sum;
	wire [15:0] rev_next;
	wire [15:0] lin;

	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_rev
			assign rev_ea[i]   = ea_i[15-i];
			assign rev_mod[i]  = rev_mod_i[15-i];
			assign rev_next[i] = rev_sum[15-i];
		end
	endgenerate

	// Reverse-carry add as plain add of mirrored operands
	assign rev_sum = rev_ea + rev_mod;
	assign lin     = ea_i + step_i;

	always @* begin
		next_o = lin;
		if (rev_en_i) begin
			next_o = rev_next;
		end else if (mod_en_i && ea_i == mod_end_i) begin
			next_o = mod_start_i;
		end
	end
endmodule

// >>> core/pds_cost.v
// Purpose: Extra cycles of a program window access
// Assumes: Repeat iteration flags come from the core sequencer
// Notes:   Pure combinational
`timescale 1ns/1ps
`include "pds_consts.vh"
module pds_cost (
	input  wire       win_i,
	input  wire [1:0] cls_i,
	input  wire       rpt_in_i,
	input  wire       rpt_edge_i,
	output reg  [1:0] extra_o
);
	always @* begin
		extra_o = `PDS_COST_NONE;
		if (win_i) begin
			if (rpt_in_i) begin
				if (rpt_edge_i) begin
					extra_o = `PDS_COST_TWO;
				end
			end else if (cls_i == `PDS_CLS_OTHER) begin
				extra_o = `PDS_COST_TWO;
			end else begin
				extra_o = `PDS_COST_ONE;
			end
		end
	end
endmodule

// >>> inc/pds_consts.vh
// Purpose: Shared constants of the program/data space access block
// Assumes: 16-bit data space, 24-bit program words
// Notes:   Address limits are plain defaults, change per memory size
`ifndef PDS_CONSTS_VH
`define PDS_CONSTS_VH

// Request operations
`define PDS_OP_RD      3'h0
`define PDS_OP_WR      3'h1
`define PDS_OP_MAC     3'h2
`define PDS_OP_TRL     3'h3
`define PDS_OP_TRH     3'h4
`define PDS_OP_TWL     3'h5
`define PDS_OP_TWH     3'h6

// Instruction classes for window cost
`define PDS_CLS_MAC    2'h0
`define PDS_CLS_MOV    2'h1
`define PDS_CLS_MOVD   2'h2
`define PDS_CLS_OTHER  2'h3

// Fixed data space layout
`define PDS_WIN_BIT    15
`define PDS_Y_BASE     16'h0800
`define PDS_Y_TOP      16'h0fff
`define PDS_RAM_TOP    16'h1fff

// Extra cycle counts
`define PDS_COST_NONE  2'h0
`define PDS_COST_ONE   2'h1
`define PDS_COST_TWO   2'h2

// Address steps
`define PDS_STEP_WORD  16'h0002
`define PDS_STEP_BYTE  16'h0001

// Register byte offsets
`define PDS_REG_CTRL   8'h00
`define PDS_REG_WPAGE  8'h04
`define PDS_REG_TPAGE  8'h08
`define PDS_REG_STAT   8'h0c
`define PDS_REG_XMS    8'h10
`define PDS_REG_XME    8'h14
`define PDS_REG_YMS    8'h18
`define PDS_REG_YME    8'h1c
`define PDS_REG_BREV   8'h20

`endif

// >>> sim/pds_access_chk.sv
// Purpose: Port assertions for the access block
// Assumes: Done is seen three edges after a request outside the window
// Notes:   Window costs are judged by the bench, not here
`timescale 1ns/1ps
`include "pds_consts.vh"
module pds_access_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        req_i,
	input wire [2:0]  op_i,
	input wire        byte_i,
	input wire [15:0] x_ea_i,
	input wire [15:0] y_ea_i,
	input wire        busy_o,
	input wire        done_o,
	input wire [15:0] rdata_o,
	input wire [23:0] prog_addr_o,
	input wire        prog_rd_o,
	input wire [2:0]  prog_wen_o,
	input wire        x_rd_o,
	input wire [1:0]  x_be_o,
	input wire        y_rd_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire        tk  = req_i && !busy_o;
	wire        ram = x_ea_i <= `PDS_RAM_TOP;
	wire        yx  = x_ea_i >= `PDS_Y_BASE && x_ea_i <= `PDS_Y_TOP;
	wire        yy  = y_ea_i >= `PDS_Y_BASE && y_ea_i <= `PDS_Y_TOP;
	wire        lsb = x_ea_i[0];
	wire [14:0] wea = x_ea_i[15:1];
	wire        tw  = req_i && (op_i == `PDS_OP_TWL || op_i == `PDS_OP_TWH);
	wire        wr  = tk && op_i == `PDS_OP_WR && ram;

	chk_tbl_time:
	assert property (tk && op_i == `PDS_OP_TRL |-> ##2 !done_o ##1 done_o)
		else $error("table read latency wrong");
	chk_tbl_addr:
	assert property (tk && op_i == `PDS_OP_TRH |=> prog_rd_o
		&& prog_addr_o[15:0] == {$past(wea), 1'b0})
		else $error("table address wrong");
	chk_mac_dual:
	assert property (tk && op_i == `PDS_OP_MAC && ram && !yx && yy
		|=> x_rd_o && y_rd_o) else $error("dual fetch missing");
	chk_x_whole:
	assert property (tk && op_i == `PDS_OP_RD && yx |=> x_rd_o && !y_rd_o)
		else $error("composite read wrong");
	chk_wr_xbus:
	assert property (wr |=> x_be_o != 2'b00 && !y_rd_o)
		else $error("write not on x bus");
	chk_byte_lane:
	assert property (wr && byte_i |=> x_be_o == ($past(lsb) ? 2'b10 : 2'b01))
		else $error("byte lane wrong");
	chk_trh_zext:
	assert property (tk && op_i == `PDS_OP_TRH && !byte_i
		|-> ##3 done_o && rdata_o[15:8] == 8'h00) else $error("high not zero");
	chk_trh_byte:
	assert property (tk && op_i == `PDS_OP_TRH && byte_i && lsb
		|-> ##3 done_o && rdata_o == 16'h0000) else $error("high byte not 0");
	chk_cross_zero:
	assert property (tk && op_i == `PDS_OP_MAC && yx
		|-> ##3 done_o && rdata_o == 16'h0000) else $error("crossed not 0");
	chk_pwr_src:
	assert property (prog_wen_o != 3'h0 |-> $past(tw))
		else $error("program write without table write");
endmodule

bind pds_access pds_access_chk i_pds_access_chk (.*);

// >>> sim/pds_access_tb.sv
// Purpose: Self-checking bench for the access block
// Assumes: Done is seen three edges after a plain request
// Notes:   Expected data follow the fixed patterns of the memory model
`timescale 1ns/1ps
`include "pds_consts.vh"
module pds_access_tb;
	reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_i, byte_i;
	reg         x_mod_i, y_mod_i, bitrev_i, rpt_in_i, rpt_first_i;
	reg         rpt_last_i, rpt_int_exit_i, rpt_int_reentry_i;
	reg  [7:0]  wb_adr_i;
	reg  [3:0]  wb_sel_i;
	reg  [31:0] wb_dat_i, rd;
	reg  [2:0]  op_i;
	reg  [1:0]  cls_i;
	reg  [15:0] x_ea_i, y_ea_i, wdata_i;
	wire        wb_ack_o, busy_o, done_o, prog_cfg_o, prog_rd_o;
	wire        x_rd_o, y_rd_o;
	wire [31:0] wb_dat_o;
	wire [15:0] rdata_o, y_rdata_o, x_next_ea_o, y_next_ea_o, x_addr_o;
	wire [15:0] x_wdata_o, x_rdata_i, y_addr_o, y_rdata_i;
	wire [23:0] prog_addr_o, prog_wdata_o, prog_rdata_i;
	wire [2:0]  prog_wen_o;
	wire [1:0]  x_be_o;
	integer     bad_count, cmp_count, cyc, lat;

	pds_access i_pds_access (.*);
	pds_mem i_pds_mem (.clk_i(clk_i), .p_addr_i(prog_addr_o),
		.p_rd_i(prog_rd_o), .p_wen_i(prog_wen_o), .p_wdata_i(prog_wdata_o),
		.p_rdata_o(prog_rdata_i), .x_addr_i(x_addr_o), .x_rd_i(x_rd_o),
		.x_be_i(x_be_o), .x_wdata_i(x_wdata_o), .x_rdata_o(x_rdata_i),
		.y_addr_i(y_addr_o), .y_rd_i(y_rd_o), .y_rdata_o(y_rdata_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Whole run is under two hundred cycles; ceiling leaves wide margin
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			bad_count = bad_count + 1;
			results;
		end
	end

	task chk(input [31:0] seen, input [31:0] exp, input [8*16:1] what);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task results;
		begin
			$display("Compares %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	task wb(input w, input [7:0] a, input [31:0] d);
		begin
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_sel_i <= 4'hf;
			wb_dat_i <= d;
			@(posedge clk_i);
			while (wb_ack_o !== 1'b1) begin
				@(posedge clk_i);
			end
			rd = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_sel_i <= 4'h0;
			@(posedge clk_i);
		end
	endtask

	// Latency counts edges from the taking edge to where done is seen
	task acc(input [2:0] o, input [1:0] c, input b, input [15:0] xa,
		input [15:0] ya, input [15:0] wd);
		begin
			req_i <= 1'b1;
			op_i <= o;
			cls_i <= c;
			byte_i <= b;
			x_ea_i <= xa;
			y_ea_i <= ya;
			wdata_i <= wd;
			@(posedge clk_i);
			req_i <= 1'b0;
			lat = 0;
			while (done_o !== 1'b1) begin
				@(posedge clk_i);
				lat = lat + 1;
			end
		end
	endtask

	task dr(input [2:0] o, input b, input [15:0] xa, input [15:0] ya,
		input [15:0] e);
		begin
			acc(o, `PDS_CLS_MOV, b, xa, ya, 16'h0000);
			chk(rdata_o, e, "read data");
		end
	endtask

	// Edge flags in order: first, last, interrupt exit, re-entry
	task win(input [1:0] c, input ri, input [3:0] re, input integer ex);
		begin
			rpt_in_i <= ri;
			{rpt_first_i, rpt_last_i, rpt_int_exit_i, rpt_int_reentry_i} <= re;
			acc(`PDS_OP_RD, c, 1'b0, 16'h8246, 16'h0000, 16'h0000);
			chk(lat, 3 + ex, "window cycles");
			chk(rdata_o, 16'h23dc, "window data");
			chk(prog_addr_o, 24'h090246, "window addr");
		end
	endtask

	task t_reg;
		begin
			wb(1'b0, `PDS_REG_TPAGE, 32'h0);
			chk(rd, 32'h0, "tpage reset");
			wb(1'b1, `PDS_REG_TPAGE, 32'h81);
			wb(1'b1, `PDS_REG_WPAGE, 32'h12);
			wb(1'b1, `PDS_REG_CTRL, 32'h1);
			wb(1'b0, `PDS_REG_TPAGE, 32'h0);
			chk(rd, 32'h81, "tpage");
			wb(1'b0, 8'h40, 32'h0);
			chk(rd, 32'h0, "unmapped");
			$display("register test done");
		end
	endtask

	// Window is on here, so table reads must ignore it
	task t_tbl;
		begin
			dr(`PDS_OP_TRL, 1'b0, 16'h8234, 16'h0, 16'h1ae5);
			chk(lat, 3, "table cycles");
			chk(prog_addr_o, 24'h818234, "table addr");
			chk(prog_cfg_o, 1'b1, "table cfg");
			dr(`PDS_OP_TRL, 1'b1, 16'h8235, 16'h0, 16'h001a);
			dr(`PDS_OP_TRL, 1'b1, 16'h8234, 16'h0, 16'h00e5);
			dr(`PDS_OP_TRH, 1'b0, 16'h8234, 16'h0, 16'h0040);
			dr(`PDS_OP_TRH, 1'b1, 16'h8234, 16'h0, 16'h0040);
			dr(`PDS_OP_TRH, 1'b1, 16'h8235, 16'h0, 16'h0000);
			acc(`PDS_OP_TWL, 2'h1, 1'b0, 16'h0010, 16'h0, 16'h1234);
			acc(`PDS_OP_TWH, 2'h1, 1'b1, 16'h0011, 16'h0, 16'h0055);
			dr(`PDS_OP_TRL, 1'b0, 16'h0010, 16'h0, 16'h1234);
			dr(`PDS_OP_TRH, 1'b0, 16'h0010, 16'h0, 16'h0052);
			acc(`PDS_OP_TWH, 2'h1, 1'b0, 16'h0010, 16'h0, 16'h00aa);
			dr(`PDS_OP_TRH, 1'b0, 16'h0010, 16'h0, 16'h00aa);
			$display("table test done");
		end
	endtask

	task t_win;
		begin
			win(`PDS_CLS_OTHER, 1'b0, 4'h0, 2);
			win(`PDS_CLS_MOV, 1'b0, 4'h0, 1);
			win(`PDS_CLS_MOVD, 1'b0, 4'h0, 1);
			win(`PDS_CLS_MAC, 1'b0, 4'h0, 1);
			win(`PDS_CLS_OTHER, 1'b1, 4'h0, 0);
			win(`PDS_CLS_MOV, 1'b1, 4'h8, 2);
			win(`PDS_CLS_MOV, 1'b1, 4'h4, 2);
			win(`PDS_CLS_MOVD, 1'b1, 4'h2, 2);
			win(`PDS_CLS_OTHER, 1'b1, 4'h1, 2);
			rpt_in_i <= 1'b0;
			rpt_int_reentry_i <= 1'b0;
			wb(1'b1, `PDS_REG_CTRL, 32'h0);
			dr(`PDS_OP_RD, 1'b0, 16'h8246, 16'h0, 16'h0000);
			$display("window test done");
		end
	endtask

	task t_data;
		begin
			acc(`PDS_OP_WR, 2'h1, 1'b0, 16'h0100, 16'h0, 16'hbeef);
			acc(`PDS_OP_WR, 2'h1, 1'b1, 16'h0103, 16'h0, 16'h0077);
			dr(`PDS_OP_RD, 1'b0, 16'h0100, 16'h0, 16'hbeef);
			dr(`PDS_OP_RD, 1'b1, 16'h0101, 16'h0, 16'h00be);
			dr(`PDS_OP_RD, 1'b0, 16'h0102, 16'h0, 16'h7781);
			dr(`PDS_OP_RD, 1'b0, 16'h0904, 16'h0, 16'h7d82);
			dr(`PDS_OP_RD, 1'b0, 16'h4000, 16'h0, 16'h0000);
			dr(`PDS_OP_MAC, 1'b0, 16'h0102, 16'h0904, 16'h7781);
			chk(y_rdata_o, 16'h7d82, "y data");
			chk(y_next_ea_o, 16'h0906, "y next");
			dr(`PDS_OP_MAC, 1'b0, 16'h0904, 16'h0102, 16'h0000);
			chk(y_rdata_o, 16'h0000, "y crossed");
			wb(1'b1, `PDS_REG_XMS, 32'h0100);
			wb(1'b1, `PDS_REG_XME, 32'h0104);
			x_mod_i <= 1'b1;
			dr(`PDS_OP_RD, 1'b0, 16'h0104, 16'h0, 16'h7d82);
			chk(x_next_ea_o, 16'h0100, "modulo wrap");
			dr(`PDS_OP_RD, 1'b0, 16'h0102, 16'h0, 16'h7781);
			chk(x_next_ea_o, 16'h0104, "modulo step");
			wb(1'b1, `PDS_REG_BREV, 32'h0008);
			bitrev_i <= 1'b1;
			acc(`PDS_OP_WR, 2'h1, 1'b0, 16'h0008, 16'h0, 16'h1111);
			chk(x_next_ea_o, 16'h0004, "bitrev write");
			dr(`PDS_OP_RD, 1'b0, 16'h0008, 16'h0, 16'h1111);
			chk(x_next_ea_o, 16'h000a, "bitrev read");
			$display("data test done");
		end
	endtask

	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, req_i, byte_i, x_mod_i} = 6'h00;
		{y_mod_i, bitrev_i, rpt_in_i, rpt_first_i} = 4'h0;
		{rpt_last_i, rpt_int_exit_i, rpt_int_reentry_i} = 3'h0;
		{wb_adr_i, wb_sel_i, wb_dat_i, op_i, cls_i} = 49'h0;
		{x_ea_i, y_ea_i, wdata_i} = 48'h0;
		bad_count = 0;
		cmp_count = 0;
		cyc = 0;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reg;
		t_tbl;
		t_win;
		t_data;
		results;
	end
endmodule

// >>> sim/pds_mem.sv
// Purpose: Program flash and data RAM behind the access block
// Assumes: Strobes are one-cycle pulses, data is due the next cycle
// Notes:   Idle read lines toggle so a late sample is caught
`timescale 1ns/1ps
module pds_mem (
	input  wire        clk_i,
	input  wire [23:0] p_addr_i,
	input  wire        p_rd_i,
	input  wire [2:0]  p_wen_i,
	input  wire [23:0] p_wdata_i,
	output reg  [23:0] p_rdata_o,
	input  wire [15:0] x_addr_i,
	input  wire        x_rd_i,
	input  wire [1:0]  x_be_i,
	input  wire [15:0] x_wdata_i,
	output reg  [15:0] x_rdata_o,
	input  wire [15:0] y_addr_i,
	input  wire        y_rd_i,
	output reg  [15:0] y_rdata_o
);
	reg [23:0] pm [0:255];
	reg [15:0] dm [0:255];
	integer    i;
	wire [7:0] pa = p_addr_i[8:1];
	wire [7:0] xa = x_addr_i[8:1];
	initial begin
		for (i = 0; i < 256; i = i + 1) begin
			pm[i] = {i[7:0] ^ 8'h5a, i[7:0], ~i[7:0]};
			dm[i] = {~i[7:0], i[7:0]};
		end
		p_rdata_o = 24'h000000;
		x_rdata_o = 16'h0000;
		y_rdata_o = 16'h0000;
	end
	always @(posedge clk_i) begin
		p_rdata_o <= p_rd_i ? pm[pa] : ~p_rdata_o;
		x_rdata_o <= x_rd_i ? dm[xa] : ~x_rdata_o;
		y_rdata_o <= y_rd_i ? dm[y_addr_i[8:1]] : ~y_rdata_o;
		if (p_wen_i[0])
			pm[pa][7:0] <= p_wdata_i[7:0];
		if (p_wen_i[1])
			pm[pa][15:8] <= p_wdata_i[15:8];
		if (p_wen_i[2])
			pm[pa][23:16] <= p_wdata_i[23:16];
		if (x_be_i[0])
			dm[xa][7:0] <= x_wdata_i[7:0];
		if (x_be_i[1])
			dm[xa][15:8] <= x_wdata_i[15:8];
	end
endmodule
